// [ldb_pkg.sv]
// package for the lcd power, duty and bias configuration block
// assumes an axi4-lite master with 32-bit data and one aligned word a register
package ldb_pkg;
   // register byte addresses
   localparam logic [3:0] LDB_PUMP_OFS = 4'h0;
   localparam logic [3:0] LDB_DUTY_OFS = 4'h4;
   localparam logic [3:0] LDB_FIRST_OFS = 4'h8;
   localparam logic [3:0] LDB_STAT_OFS = 4'hC;
   // reset values
   localparam logic [7:0] LDB_PUMP_RST = 8'h00;
   localparam logic [7:0] LDB_DUTY_RST = 8'h00;
   localparam logic [7:0] LDB_FIRST_RST = 8'h00;
   // writable bit masks
   localparam logic [7:0] LDB_PUMP_MASK = 8'h0B;
   localparam logic [7:0] LDB_DUTY_MASK = 8'hE7;
   localparam logic [7:0] LDB_FIRST_MASK = 8'hF7;
   // field positions
   localparam int LDB_SRC_BIT = 3;
   localparam int LDB_PVS_LSB = 0;
   localparam int LDB_CKD_LSB = 5;
   localparam int LDB_DTY_LSB = 1;
   localparam int LDB_BIAS_BIT = 0;
   localparam int LDB_TYPE_BIT = 6;
   localparam int LDB_CPS_LSB = 4;
   localparam int LDB_EN_BIT = 0;
   // axi responses
   localparam logic [1:0] LDB_RESP_OKAY = 2'h0;
   localparam logic [1:0] LDB_RESP_SLVERR = 2'h2;
   // pump clock divisor exponents, log2 of the divisor
   localparam logic [2:0] LDB_DIV_MAX_EXP = 3'h7;
   localparam logic [2:0] LDB_DIV_MIN_EXP = 3'h1;
   typedef enum logic [1:0] {
      LDB_DUTY_QUARTER,
      LDB_DUTY_SIXTH,
      LDB_DUTY_EIGHTH,
      LDB_DUTY_NONE
   } ldb_duty_t;
endpackage

// [ldb_reg8.sv]
// one 8-bit control register with a write mask
// assumes synchronous reset release and a one-cycle write strobe
`timescale 1ns/10ps
`default_nettype none
module ldb_reg8
   import ldb_pkg::*;
#(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WR_MASK = 8'hFF
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // write side
   input wire logic wr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] q_out
);
   logic [7:0] q_reg;
   logic [7:0] q_next;
   // unimplemented positions keep zero
   assign q_next = wdata_in & WR_MASK;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q_reg <= RST_VAL;
      end else if (ce_in && wr_in) begin
         q_reg <= q_next; // [R15]
      end
   end
   assign q_out = q_reg;
endmodule
`default_nettype wire

// [ldb_com_rel.sv]
// per common line release decode
// assumes duty code from the duty register
`timescale 1ns/10ps
`default_nettype none
module ldb_com_rel
   import ldb_pkg::*;
(
   input wire logic [1:0] duty_in,
   output logic [7:0] com_used_out,
   output logic [3:0] com_count_out
);
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_com
         assign com_used_out[g] = (duty_in == LDB_DUTY_QUARTER) ? (g < 4) :
            (duty_in == LDB_DUTY_SIXTH) ? (g < 6) :
            (duty_in == LDB_DUTY_EIGHTH); // [R08]
      end
   endgenerate
   assign com_count_out = (duty_in == LDB_DUTY_QUARTER) ? 4'h4 :
      (duty_in == LDB_DUTY_SIXTH) ? 4'h6 :
      (duty_in == LDB_DUTY_EIGHTH) ? 4'h8 : 4'h0; // [R07]
endmodule
`default_nettype wire

// [ldb_top.sv]
// lcd power, duty and bias configuration with an axi4-lite slave
// assumes one master, one write and one read outstanding at a time
// Functional notes
// [R01] pump bits 7-4, duty bits 4-3 read zero
// [R02] pump bit 2 reads zero
// [R03] source bit picks supply pin or pump
// [R04] capacitive type or driver off kills pump
// [R05] voltage field selects pump output level
// [R06] three-bit field sets capacitive pump divisor
// [R07] duty field selects four, six, eight commons
// [R08] unused common pins are released
// [R09] bias bit: third or quarter, quarter resistive
// [R10] capacitive type enables capacitive pump
// [R11] third bias four levels, quarter five
// [R12] first register field picks capacitive source
// [R13] type bit: 0 resistive, 1 capacitive
// [R14] sleep keeps display off
// [R15] unimplemented bit writes have no effect
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module ldb_top
   import ldb_pkg::*;
(
   // clock, reset, enable
   input wire logic CLOCK_IN,
   input wire logic NRST_IN,
   input wire logic CE_IN,
   input wire logic SLEEP_IN,
   // axi write address and data
   input wire logic [3:0] AWADDR_IN,
   input wire logic AWVALID_IN,
   output logic AWREADY_OUT,
   input wire logic [31:0] WDATA_IN,
   input wire logic [3:0] WSTRB_IN,
   input wire logic WVALID_IN,
   output logic WREADY_OUT,
   // axi write response
   output logic [1:0] BRESP_OUT,
   output logic BVALID_OUT,
   input wire logic BREADY_IN,
   // axi read
   input wire logic [3:0] ARADDR_IN,
   input wire logic ARVALID_IN,
   output logic ARREADY_OUT,
   output logic [31:0] RDATA_OUT,
   output logic [1:0] RRESP_OUT,
   output logic RVALID_OUT,
   input wire logic RREADY_IN,
   // analogue and waveform controls
   output logic SUPPLY_PIN_SEL_OUT,
   output logic RES_PUMP_EN_OUT,
   output logic [1:0] PUMP_VOLT_OUT,
   output logic CAP_PUMP_EN_OUT,
   output logic [2:0] CAP_DIV_EXP_OUT,
   output logic [1:0] CAP_SRC_OUT,
   output logic [7:0] COM_USED_OUT,
   output logic [3:0] COM_COUNT_OUT,
   output logic QUARTER_BIAS_OUT,
   output logic [2:0] BIAS_LEVELS_OUT,
   output logic DISPLAY_ON_OUT
);
   logic rst_s1_reg;
   logic rst_n;
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // write channel capture, either order
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [3:0] awaddr_reg;
   logic [7:0] wbyte_reg;
   logic wstrb0_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic awready_reg;
   logic wready_reg;
   logic arready_reg;
   // a beat moves only while ready is shown, never on valid alone
   wire aw_take = AWVALID_IN && awready_reg;
   wire w_take = WVALID_IN && wready_reg;
   wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
   wire wr_lane = wr_fire && wstrb0_reg;
   wire wr_pump = wr_lane && (awaddr_reg == LDB_PUMP_OFS);
   wire wr_duty = wr_lane && (awaddr_reg == LDB_DUTY_OFS);
   wire wr_first = wr_lane && (awaddr_reg == LDB_FIRST_OFS);
   wire wr_known = (awaddr_reg == LDB_PUMP_OFS) ||
      (awaddr_reg == LDB_DUTY_OFS) || (awaddr_reg == LDB_FIRST_OFS);

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg <= 4'h0;
      end else if (CE_IN) begin
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= {AWADDR_IN[3:2], 2'b00};
         end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         w_hold_reg <= 1'b0;
         wbyte_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
      end else if (CE_IN) begin
         if (w_take) begin
            w_hold_reg <= 1'b1;
            wbyte_reg <= WDATA_IN[7:0];
            wstrb0_reg <= WSTRB_IN[0];
         end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= LDB_RESP_OKAY;
      end else if (CE_IN) begin
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? LDB_RESP_OKAY : LDB_RESP_SLVERR;
         end else if (BREADY_IN) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // control registers; masks keep unimplemented bits at zero
   logic [7:0] pump_q;
   logic [7:0] duty_q;
   logic [7:0] first_q;
   ldb_reg8 #(.RST_VAL(LDB_PUMP_RST), .WR_MASK(LDB_PUMP_MASK)) u_pump (
      .clk_in(CLOCK_IN),
      .rst_n_in(rst_n),
      .ce_in(CE_IN),
      .wr_in(wr_pump),
      .wdata_in(wbyte_reg),
      .q_out(pump_q)
   ); // [R01] [R02]
   ldb_reg8 #(.RST_VAL(LDB_DUTY_RST), .WR_MASK(LDB_DUTY_MASK)) u_duty (
      .clk_in(CLOCK_IN),
      .rst_n_in(rst_n),
      .ce_in(CE_IN),
      .wr_in(wr_duty),
      .wdata_in(wbyte_reg),
      .q_out(duty_q)
   ); // [R01]
   ldb_reg8 #(.RST_VAL(LDB_FIRST_RST), .WR_MASK(LDB_FIRST_MASK)) u_first (
      .clk_in(CLOCK_IN),
      .rst_n_in(rst_n),
      .ce_in(CE_IN),
      .wr_in(wr_first),
      .wdata_in(wbyte_reg),
      .q_out(first_q)
   );

   // decode of the configuration fields
   wire drive_power_source_sel = pump_q[LDB_SRC_BIT];
   wire [1:0] pump_voltage_sel = pump_q[LDB_PVS_LSB +: 2];
   wire [2:0] cap_pump_clock_div = duty_q[LDB_CKD_LSB +: 3];
   wire [1:0] duty_sel = duty_q[LDB_DTY_LSB +: 2];
   wire bias_sel = duty_q[LDB_BIAS_BIT];
   wire drive_type_sel = first_q[LDB_TYPE_BIT];
   wire [1:0] cap_power_source_sel = first_q[LDB_CPS_LSB +: 2];
   wire display_driver_on = first_q[LDB_EN_BIT];
   wire disp_on = display_driver_on && !SLEEP_IN; // [R14]
   wire cap_type = drive_type_sel; // [R13]
   wire res_pump = drive_power_source_sel && !cap_type &&
      display_driver_on; // [R03] [R04]
   // codes 110 and 111 both give divide by two
   wire [2:0] div_exp = (cap_pump_clock_div >= 3'h6) ? LDB_DIV_MIN_EXP :
      LDB_DIV_MAX_EXP - cap_pump_clock_div; // [R06]
   // quarter bias only counts for resistive drive
   wire quarter = bias_sel && !cap_type; // [R09]
   wire [2:0] levels = quarter ? 3'h5 : 3'h4; // [R11]
   // eighth duty is resistive only; capacitive falls back to sixth
   wire [1:0] duty_eff = (cap_type && duty_sel == LDB_DUTY_EIGHTH) ?
      LDB_DUTY_SIXTH : duty_sel; // [R07]
   logic [7:0] com_used;
   logic [3:0] com_count;
   ldb_com_rel u_com (
      .duty_in(duty_eff),
      .com_used_out(com_used),
      .com_count_out(com_count)
   ); // [R08]

   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         SUPPLY_PIN_SEL_OUT <= 1'b1;
         RES_PUMP_EN_OUT <= 1'b0;
         PUMP_VOLT_OUT <= 2'h0;
         CAP_PUMP_EN_OUT <= 1'b0;
         CAP_DIV_EXP_OUT <= LDB_DIV_MAX_EXP;
         CAP_SRC_OUT <= 2'h0;
         COM_USED_OUT <= 8'h0F;
         COM_COUNT_OUT <= 4'h4;
         QUARTER_BIAS_OUT <= 1'b0;
         BIAS_LEVELS_OUT <= 3'h4;
         DISPLAY_ON_OUT <= 1'b0;
      end else if (CE_IN) begin
         SUPPLY_PIN_SEL_OUT <= !res_pump; // [R03]
         RES_PUMP_EN_OUT <= res_pump; // [R04]
         PUMP_VOLT_OUT <= pump_voltage_sel; // [R05]
         CAP_PUMP_EN_OUT <= cap_type && display_driver_on; // [R10]
         CAP_DIV_EXP_OUT <= div_exp; // [R06]
         CAP_SRC_OUT <= cap_power_source_sel; // [R12]
         COM_USED_OUT <= com_used; // [R08]
         COM_COUNT_OUT <= com_count;
         QUARTER_BIAS_OUT <= quarter; // [R09]
         BIAS_LEVELS_OUT <= levels; // [R11]
         DISPLAY_ON_OUT <= disp_on; // [R14]
      end
   end

   // read channel, one cycle after address taken
   logic rvalid_reg;
   logic [7:0] rbyte_reg;
   logic [1:0] rresp_reg;
   wire ar_take = ARVALID_IN && arready_reg;
   wire [3:0] raddr = {ARADDR_IN[3:2], 2'b00};
   wire [7:0] stat_byte = {RES_PUMP_EN_OUT, CAP_PUMP_EN_OUT,
      DISPLAY_ON_OUT, 1'b0, COM_COUNT_OUT};
   wire r_known = (raddr == LDB_PUMP_OFS) || (raddr == LDB_DUTY_OFS) ||
      (raddr == LDB_FIRST_OFS) || (raddr == LDB_STAT_OFS);
   wire [7:0] rsel = (raddr == LDB_PUMP_OFS) ? pump_q :
      (raddr == LDB_DUTY_OFS) ? duty_q :
      (raddr == LDB_FIRST_OFS) ? first_q :
      (raddr == LDB_STAT_OFS) ? stat_byte : 8'h00; // [R01] [R02]
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rbyte_reg <= 8'h00;
         rresp_reg <= LDB_RESP_OKAY;
      end else if (CE_IN) begin
         if (ar_take) begin
            rvalid_reg <= 1'b1;
            rbyte_reg <= rsel;
            rresp_reg <= r_known ? LDB_RESP_OKAY : LDB_RESP_SLVERR;
         end else if (RREADY_IN) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ready flags registered so outputs come from flip-flops
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         arready_reg <= 1'b0;
      end else if (CE_IN) begin
         awready_reg <= !aw_hold_reg && !aw_take && !bvalid_reg && !wr_fire;
         wready_reg <= !w_hold_reg && !w_take && !bvalid_reg && !wr_fire;
         arready_reg <= !rvalid_reg && !ar_take;
      end
   end
   assign AWREADY_OUT = awready_reg;
   assign WREADY_OUT = wready_reg;
   assign ARREADY_OUT = arready_reg;
   assign BVALID_OUT = bvalid_reg;
   assign BRESP_OUT = bresp_reg;
   assign RVALID_OUT = rvalid_reg;
   assign RDATA_OUT = {24'h000000, rbyte_reg};
   assign RRESP_OUT = rresp_reg;
endmodule
`default_nettype wire

// [ldb_chk.sv]
// checker for the lcd power, duty and bias block
// assumes it is bound to ldb_top and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module ldb_chk
   import ldb_pkg::*;
(
   // clock and control
   input wire logic CLOCK_IN,
   input wire logic NRST_IN,
   input wire logic CE_IN,
   input wire logic SLEEP_IN,
   // read channel
   input wire logic [3:0] ARADDR_IN,
   input wire logic ARVALID_IN,
   input wire logic ARREADY_OUT,
   input wire logic [31:0] RDATA_OUT,
   input wire logic RVALID_OUT,
   // controls
   input wire logic SUPPLY_PIN_SEL_OUT,
   input wire logic RES_PUMP_EN_OUT,
   input wire logic CAP_PUMP_EN_OUT,
   input wire logic [2:0] CAP_DIV_EXP_OUT,
   input wire logic [7:0] COM_USED_OUT,
   input wire logic [3:0] COM_COUNT_OUT,
   input wire logic QUARTER_BIAS_OUT,
   input wire logic [2:0] BIAS_LEVELS_OUT,
   input wire logic DISPLAY_ON_OUT
);
   logic [3:0] rd_addr_reg;
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (!NRST_IN);
   // address of the read in flight, to judge its data
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) rd_addr_reg <= 4'h0;
      else if (ARVALID_IN && ARREADY_OUT && CE_IN) rd_addr_reg <= ARADDR_IN;
   end
   sequence ar_take;
      ARVALID_IN && ARREADY_OUT && CE_IN;
   endsequence
   sequence rd_of(logic [3:0] a);
      RVALID_OUT && rd_addr_reg == a;
   endsequence
   chk_rd_answer: assert property (ar_take |=> RVALID_OUT)
      else $error("read answer late");
   chk_pump_hi_zero: assert property (
      rd_of(LDB_PUMP_OFS) |-> RDATA_OUT[7:4] == 4'h0)
      else $error("pump high bits set");
   chk_pump_b2_zero: assert property (
      rd_of(LDB_PUMP_OFS) |-> !RDATA_OUT[2])
      else $error("pump bit 2 set");
   chk_duty_gap_zero: assert property (
      rd_of(LDB_DUTY_OFS) |-> RDATA_OUT[4:3] == 2'h0)
      else $error("duty gap bits set");
   chk_res_vs_src: assert property (
      RES_PUMP_EN_OUT |-> !SUPPLY_PIN_SEL_OUT)
      else $error("pump on with pin supply");
   chk_pump_excl: assert property (
      !(RES_PUMP_EN_OUT && CAP_PUMP_EN_OUT))
      else $error("both pumps on");
   chk_div_range: assert property (
      CAP_DIV_EXP_OUT >= LDB_DIV_MIN_EXP)
      else $error("divisor below two");
   chk_com_count: assert property (
      COM_COUNT_OUT == 4'($countones(COM_USED_OUT))
      && COM_USED_OUT inside {8'h00, 8'h0F, 8'h3F, 8'hFF})
      else $error("common lines inconsistent");
   chk_quarter_res: assert property (
      QUARTER_BIAS_OUT |-> !CAP_PUMP_EN_OUT)
      else $error("quarter bias in cap mode");
   chk_bias_levels: assert property (
      BIAS_LEVELS_OUT == (QUARTER_BIAS_OUT ? 3'h5 : 3'h4))
      else $error("bias level count wrong");
   chk_sleep_off: assert property (
      SLEEP_IN && CE_IN |=> !DISPLAY_ON_OUT)
      else $error("display on in sleep");
endmodule
bind ldb_top ldb_chk chk_u(.CLOCK_IN, .NRST_IN, .CE_IN, .SLEEP_IN,
   .ARADDR_IN, .ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RVALID_OUT,
   .SUPPLY_PIN_SEL_OUT, .RES_PUMP_EN_OUT, .CAP_PUMP_EN_OUT,
   .CAP_DIV_EXP_OUT, .COM_USED_OUT, .COM_COUNT_OUT, .QUARTER_BIAS_OUT,
   .BIAS_LEVELS_OUT, .DISPLAY_ON_OUT);
`default_nettype wire

// [tb.sv]
// random testbench for the lcd power, duty and bias block
// assumes ldb_top with its axi4-lite slave and one clock
`timescale 1ns/10ps
`default_nettype none
module tb
   import ldb_pkg::*;
;
   logic clk = 0, nrst = 0, slp = 0, awv = 0, wv = 0, bre = 0;
   logic arv = 0, rre = 0;
   logic [3:0] awa = 0, ara = 0, wst = 0;
   logic [31:0] wd = 0, x;
   logic awr, wrd, bv, arr, rv, sup, rpe, cpe, qb, don;
   logic [1:0] br, rr, pv, cs;
   logic [31:0] rd;
   logic [2:0] cde, bl;
   logic [7:0] cu, p, d, f;
   logic [3:0] cc;
   int err_count = 0, tests_run = 0;
   wire logic [31:0] obs = {5'h0, sup, rpe, pv, cpe, cde, cs, cu, cc, qb,
      bl, don};
   always #25 clk = ~clk;
   ldb_top dut_u(.CLOCK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1),
      .SLEEP_IN(slp), .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr),
      .WDATA_IN(wd), .WSTRB_IN(wst), .WVALID_IN(wv), .WREADY_OUT(wrd),
      .BRESP_OUT(br), .BVALID_OUT(bv), .BREADY_IN(bre), .ARADDR_IN(ara),
      .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rd), .RRESP_OUT(rr),
      .RVALID_OUT(rv), .RREADY_IN(rre), .SUPPLY_PIN_SEL_OUT(sup),
      .RES_PUMP_EN_OUT(rpe), .PUMP_VOLT_OUT(pv), .CAP_PUMP_EN_OUT(cpe),
      .CAP_DIV_EXP_OUT(cde), .CAP_SRC_OUT(cs), .COM_USED_OUT(cu),
      .COM_COUNT_OUT(cc), .QUARTER_BIAS_OUT(qb), .BIAS_LEVELS_OUT(bl),
      .DISPLAY_ON_OUT(don));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // expected control outputs, packed like obs
   function automatic logic [31:0] ctl(input logic [7:0] p, d, f,
      input logic s);
      logic t, e, q;
      logic [3:0] c;
      t = f[LDB_TYPE_BIT];
      e = f[LDB_EN_BIT];
      q = d[0] & !t;
      c = d[2:1] == 2'h0 ? 4'h4 : d[2:1] == 2'h1 ? 4'h6 :
         d[2:1] == 2'h3 ? 4'h0 : t ? 4'h6 : 4'h8;
      return {5'h0, !(p[3] & !t & e), p[3] & !t & e, p[1:0], t & e,
         d[7:5] > 3'h5 ? 3'h1 : 3'h7 - d[7:5], f[5:4], ~(8'hFF << c), c, q,
         q ? 3'h5 : 3'h4, e & !s};
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] v,
      input logic [3:0] s, input logic [1:0] er);
      logic aw, w;
      aw = 1;
      w = 1;
      // upper data bits are noise the slave must drop
      wd <= ($urandom() & 32'hFFFFFF00) | {24'h0, v};
      awa <= a;
      wst <= s;
      awv <= 1;
      wv <= 1;
      bre <= 1;
      while (aw || w) begin
         @(posedge clk);
         if (aw && awr) begin aw = 0; awv <= 0; end
         if (w && wrd) begin w = 0; wv <= 0; end
      end
      do @(posedge clk); while (!bv);
      chk({30'h0, br}, {30'h0, er});
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] e,
      input logic [1:0] er);
      ara <= a;
      arv <= 1;
      rre <= 1;
      do @(posedge clk); while (!arr);
      arv <= 0;
      do @(posedge clk); while (!rv);
      chk(rd, e);
      chk({30'h0, rr}, {30'h0, er});
   endtask
   task conclude;
      if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #2000000;
      err_count++;
      conclude;
   end
   initial begin
      void'($urandom(48));
      repeat (20) @(posedge clk);
      nrst <= 1;
      repeat (3) @(posedge clk);
      chk(obs, ctl(8'h0, 8'h0, 8'h0, 1'b0));
      for (int i = 0; i < 60; i++) begin
         p = 8'($urandom());
         d = 8'($urandom());
         f = i == 0 ? 8'hFF : 8'($urandom());
         if (i == 0) begin p = 8'hFF; d = 8'hFF; end
         slp <= 1'($urandom());
         wr(LDB_PUMP_OFS, p, 4'hF, LDB_RESP_OKAY);
         wr(LDB_DUTY_OFS, d, 4'hF, LDB_RESP_OKAY);
         wr(LDB_FIRST_OFS, f, 4'hF, LDB_RESP_OKAY);
         repeat (2) @(posedge clk);
         x = ctl(p, d, f, slp);
         chk(obs, x);
         rdc(LDB_PUMP_OFS, {24'h0, p & LDB_PUMP_MASK}, 0);
         rdc(LDB_DUTY_OFS, {24'h0, d & LDB_DUTY_MASK}, 0);
         rdc(LDB_FIRST_OFS, {24'h0, f & LDB_FIRST_MASK}, 0);
         rdc(LDB_STAT_OFS, {24'h0, x[25], x[22], x[0], 1'b0, x[8:5]},
            0);
      end
      // masked strobe and read-only status leave registers alone
      wr(LDB_PUMP_OFS, ~p, 4'h0, LDB_RESP_OKAY);
      wr(LDB_STAT_OFS, 8'hFF, 4'hF, LDB_RESP_SLVERR);
      // low address bits are dropped, so this aliases the pump word
      rdc(4'h2, {24'h0, p & LDB_PUMP_MASK}, LDB_RESP_OKAY);
      rdc(LDB_PUMP_OFS, {24'h0, p & LDB_PUMP_MASK}, 0);
      conclude;
   end
endmodule
`default_nettype wire
